/* src/dcp_top.sv */
// Command and data port of the DDR2 ECC DIMM block, with the processor window
// and its two control words. Assumes user logic on the same fabric clock.
`timescale 1ns/1ns
module dcp_top import dcp_pkg::*; #(
  parameter int VARIANT = 1,
  parameter int WIDE_DATA = 0,
  parameter int HALF_BURST = 0,
  parameter int BANK_MGMT = 0,
  parameter int ROW13 = 1,
  parameter int MC_CLK_REQ = 266,
  parameter int QUEUE_DEPTH = 8,
  parameter int MEM_AW = 10
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic [UNIT_W-1:0] data_in,
  input wire logic [UNIT_BE-1:0] write_byte_lanes,
  input wire logic read_not_write_select,
  input wire logic cmd_valid,
  output logic cmd_ack,
  output logic [HALF_W-1:0] data_out,
  output logic rd_valid,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [LIN_W-1:0] cpu_addr,
  input wire logic [CPU_W-1:0] cpu_wdata,
  input wire logic [CPU_BE-1:0] cpu_be,
  output logic [CPU_W-1:0] cpu_rdata,
  output logic cpu_done,
  input wire logic reg_wr,
  input wire logic reg_index,
  input wire logic [REG_W-1:0] reg_wdata,
  output logic [REG_W-1:0] reg_rdata
);
  // ---------------------------------------------------------------
  // Variant options
  // ---------------------------------------------------------------
  localparam bit EFF_WIDE = (VARIANT == 1) && (WIDE_DATA != 0);
  localparam bit EFF_HALF = (VARIANT == 1) && (HALF_BURST != 0);
  localparam bit EFF_BANKS = (VARIANT != 1) || (BANK_MGMT != 0);
  localparam int MC_MHZ = (VARIANT == 1) ? MC_CLK_REQ : dcp_mc_clock(MC_CLK_REQ);
  localparam int ROW_MISS_CYC = dcp_fab_cycles(ROW_MISS_MC, MC_MHZ);
  localparam int DIR_TURN_CYC = dcp_fab_cycles(DIR_TURN_MC, MC_MHZ);
  localparam int SLOTS = EFF_BANKS ? OPEN_BANKS : 1;
  localparam int CW = $bits(dcp_cmd_s);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic [ROW_W-1:0] dec_row;
  logic [LOC_W-1:0] dec_loc;

  always_comb begin
    dec_row = address[ROW_MSB:ROW_LSB];
    if (ROW13 != 0) begin
      dec_row[ROW_W-1] = 1'b0;
    end
    if (VARIANT == 1) begin
      dec_loc = {address[BANK_MSB:BANK_LSB], dec_row, address[RANK_BIT],
                 address[COL_MSB:COL_LSB]};
    end else begin
      dec_loc = {1'b0, address[LIN_W-1:0]};
    end
  end

  // ---------------------------------------------------------------
  // Command capture
  // ---------------------------------------------------------------
  logic pend;
  logic [HALF_W-1:0] first_data;
  logic [HALF_BE-1:0] first_be;
  logic push_try;
  logic q_in_ready;
  logic q_out_valid;
  logic q_out_ready;
  dcp_cmd_s in_cmd;
  dcp_cmd_s head;

  always_comb begin
    in_cmd.rnw = read_not_write_select;
    in_cmd.loc = dec_loc;
    in_cmd.data = '0;
    in_cmd.be = '0;
    push_try = 1'b0;
    if (cmd_valid && read_not_write_select && !pend) begin
      push_try = 1'b1;
    end else if (cmd_valid && !read_not_write_select && pend) begin
      push_try = 1'b1;
      if (EFF_WIDE) begin
        in_cmd.data = {data_in[UNIT_W-1:HALF_W], first_data};
        in_cmd.be = {write_byte_lanes[UNIT_BE-1:HALF_BE], first_be};
      end else if (EFF_HALF) begin
        in_cmd.data = {{HALF_W{1'b0}}, first_data};
        in_cmd.be = {{HALF_BE{1'b1}}, first_be};
      end else begin
        in_cmd.data = {data_in[HALF_W-1:0], first_data};
        in_cmd.be = {write_byte_lanes[HALF_BE-1:0], first_be};
      end
    end
  end

  // First write beat waits for its partner on the next clock
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pend <= 1'b0;
    end else if (cmd_valid && !read_not_write_select && !pend) begin
      pend <= 1'b1;
    end else begin
      pend <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      first_data <= '0;
      first_be <= '0;
    end else if (cmd_valid && !read_not_write_select && !pend) begin
      first_data <= data_in[HALF_W-1:0];
      first_be <= write_byte_lanes[HALF_BE-1:0];
    end
  end

  // Acknowledge drops in the very cycle a full queue refuses a command
  assign cmd_ack = !(push_try && !q_in_ready);

  dcp_cmd_queue #(.W(CW), .DEPTH(QUEUE_DEPTH)) u_queue (
    .clk(clk),
    .nrst(nrst),
    .in_valid(push_try),
    .in_ready(q_in_ready),
    .in_data(in_cmd),
    .out_valid(q_out_valid),
    .out_ready(q_out_ready),
    .out_data(head)
  );

  // ---------------------------------------------------------------
  // Control words
  // ---------------------------------------------------------------
  logic [REG_W-1:0] segment_select;
  logic controller_ready;
  logic [$clog2(INIT_CYC+1)-1:0] init_cnt;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      segment_select <= SEGMENT_RESET;
    end else if (reg_wr && reg_index == REG_SEGMENT) begin
      segment_select <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      init_cnt <= '0;
      controller_ready <= 1'b0;
    end else if (init_cnt == ($clog2(INIT_CYC+1))'(INIT_CYC)) begin
      controller_ready <= 1'b1;
    end else begin
      init_cnt <= init_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_index == REG_READY) begin
      reg_rdata <= controller_ready ? READY_VALUE : '0;
    end else begin
      reg_rdata <= segment_select;
    end
  end

  // ---------------------------------------------------------------
  // Open bank tracking
  // ---------------------------------------------------------------
  logic [1:0] head_bank;
  logic [ROW_W-1:0] head_row;
  logic slot_valid [0:OPEN_BANKS-1];
  logic [1:0] slot_bank [0:OPEN_BANKS-1];
  logic [ROW_W-1:0] slot_row [0:OPEN_BANKS-1];
  logic [1:0] victim;
  logic row_hit;
  logic bank_seen;
  logic [1:0] bank_slot;
  logic last_rnw;
  logic [WAIT_W-1:0] next_wait;

  assign head_bank = head.loc[LOC_W-1:LOC_BANK_LSB];
  assign head_row = head.loc[LOC_BANK_LSB-1:LOC_ROW_LSB];

  always_comb begin
    row_hit = 1'b0;
    bank_seen = 1'b0;
    bank_slot = victim;
    for (int i = 0; i < SLOTS; i++) begin
      if (slot_valid[i] && slot_bank[i] == head_bank) begin
        bank_seen = 1'b1;
        bank_slot = 2'(i);
        row_hit = (slot_row[i] == head_row);
      end
    end
    next_wait = '0;
    if (!row_hit) begin
      next_wait = WAIT_W'(ROW_MISS_CYC);
    end
    if (head.rnw != last_rnw) begin
      next_wait = next_wait + WAIT_W'(DIR_TURN_CYC);
    end
  end

  // ---------------------------------------------------------------
  // Command engine
  // ---------------------------------------------------------------
  dcp_state_e state;
  dcp_cmd_s cur;
  logic [WAIT_W-1:0] wait_cnt;
  logic cpu_pend;
  logic cpu_pend_we;
  logic [LIN_W-1:0] cpu_pend_addr;
  logic [CPU_W-1:0] cpu_pend_wdata;
  logic [CPU_BE-1:0] cpu_pend_be;
  logic take_cmd;
  logic [LOC_W-1:0] cur_loc1;
  logic [LOC_W-1:0] cpu_loc;
  dcp_mem_if #(.AW(MEM_AW)) mem_port ();

  assign take_cmd = (state == ST_IDLE) && controller_ready && !cpu_pend && q_out_valid;
  assign q_out_ready = take_cmd;
  assign cur_loc1 = cur.loc + LOC_W'(1);
  assign cpu_loc = LOC_W'({segment_select, cpu_pend_addr[LIN_W-1:CPU_LSB]});

  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < OPEN_BANKS; i++) begin
        slot_valid[i] <= 1'b0;
        slot_bank[i] <= '0;
        slot_row[i] <= '0;
      end
      victim <= '0;
      last_rnw <= 1'b0;
    end else if (take_cmd) begin
      slot_valid[bank_slot] <= 1'b1;
      slot_bank[bank_slot] <= head_bank;
      slot_row[bank_slot] <= head_row;
      last_rnw <= head.rnw;
      if (!bank_seen) begin
        victim <= (victim == 2'(SLOTS - 1)) ? '0 : victim + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
      cur <= '0;
      wait_cnt <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (controller_ready && cpu_pend) begin
            state <= ST_CPU;
          end else if (take_cmd) begin
            cur <= head;
            wait_cnt <= next_wait;
            state <= (next_wait == '0) ? ST_BEAT0 : ST_WAIT;
          end
        end
        ST_WAIT: begin
          wait_cnt <= wait_cnt - 1'b1;
          if (wait_cnt == WAIT_W'(1)) begin
            state <= ST_BEAT0;
          end
        end
        ST_BEAT0: state <= ST_BEAT1;
        ST_BEAT1: state <= ST_IDLE;
        ST_CPU: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Processor requests wait here until the engine is free
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cpu_pend <= 1'b0;
      cpu_pend_we <= 1'b0;
      cpu_pend_addr <= '0;
      cpu_pend_wdata <= '0;
      cpu_pend_be <= '0;
    end else if (cpu_req && !cpu_pend) begin
      cpu_pend <= 1'b1;
      cpu_pend_we <= cpu_we;
      cpu_pend_addr <= cpu_addr;
      cpu_pend_wdata <= cpu_wdata;
      cpu_pend_be <= cpu_be;
    end else if (state == ST_CPU) begin
      cpu_pend <= 1'b0;
    end
  end

  // Each 288-bit unit is two 144-bit locations, each two 72-bit lanes
  always_comb begin
    mem_port.en = 1'b0;
    mem_port.we = 1'b0;
    mem_port.addr = cur.loc[MEM_AW-1:0];
    mem_port.be = '0;
    mem_port.wdata = '0;
    case (state)
      ST_BEAT0: begin
        mem_port.en = 1'b1;
        mem_port.we = !cur.rnw;
        mem_port.be = cur.be[HALF_BE-1:0];
        mem_port.wdata = cur.data[HALF_W-1:0];
      end
      ST_BEAT1: begin
        mem_port.en = 1'b1;
        mem_port.we = !cur.rnw;
        mem_port.addr = cur_loc1[MEM_AW-1:0];
        mem_port.be = cur.be[UNIT_BE-1:HALF_BE];
        mem_port.wdata = cur.data[UNIT_W-1:HALF_W];
      end
      ST_CPU: begin
        mem_port.en = 1'b1;
        mem_port.we = cpu_pend_we;
        mem_port.addr = cpu_loc[MEM_AW-1:0];
        mem_port.be = {1'b0, cpu_pend_be[CPU_BE-1:8], 1'b0, cpu_pend_be[7:0]};
        mem_port.wdata = {8'h00, cpu_pend_wdata[CPU_W-1:LANE_DATA],
                          8'h00, cpu_pend_wdata[LANE_DATA-1:0]};
      end
      default: begin
        mem_port.en = 1'b0;
      end
    endcase
  end

  dcp_store #(.AW(MEM_AW)) u_store (
    .clk(clk),
    .mp(mem_port)
  );

  // ---------------------------------------------------------------
  // Read return paths
  // ---------------------------------------------------------------
  logic rd_issue;
  logic cpu_issue;
  logic cpu_issue_rd;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_issue <= 1'b0;
      rd_valid <= 1'b0;
      data_out <= '0;
    end else begin
      rd_issue <= (state == ST_BEAT0 || state == ST_BEAT1) && cur.rnw;
      rd_valid <= rd_issue;
      if (rd_issue) begin
        data_out <= mem_port.rdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cpu_issue <= 1'b0;
      cpu_issue_rd <= 1'b0;
      cpu_done <= 1'b0;
      cpu_rdata <= '0;
    end else begin
      cpu_issue <= (state == ST_CPU);
      cpu_issue_rd <= (state == ST_CPU) && !cpu_pend_we;
      cpu_done <= cpu_issue;
      if (cpu_issue_rd) begin
        cpu_rdata <= {mem_port.rdata[LANE_W+LANE_DATA-1:LANE_W],
                      mem_port.rdata[LANE_DATA-1:0]};
      end
    end
  end
endmodule

/* src/dcp_pkg.sv */
// Shared constants and types of the DDR2 DIMM command port.
// Assumes a single 250 MHz fabric clock and a synchronous active-low reset.
// How it works
// - Variant one: column 12:3, rank 13, row 27:14, bank 29:28, bits 31:30 ignored.
// - Low three address bits ignored; user steps by eight per 144-bit location.
// - With 13-bit row chips, address bit 27 is ignored and regions alias.
// - Parity lanes hold data, so each memory word is 72 bits.
// - Every command-port access moves four 72-bit beats, a 288-bit unit; a processor access moves one 144-bit location.
// - Write unit arrives as two 144-bit halves; wide mode still takes two beats, upper half from the second beat's upper lanes.
// - Half-fill mode keeps 144 bits per command, still writes 288 bits.
// - Variant two: no half-fill, no wide bus, bank opening on, no tags.
// - Variant two controller clock is 150, 200, 266, 300 or 333, else 266.
// - Read words come after some latency, one per clock, framed by read-valid.
// - Command-accepted stays high, drops in the cycle a full queue refuses.
// - Variant two handles one rank only; half a dual-rank module is reachable.
// - Variant two takes linear word addresses, module size over 16 bytes.
// - Processor window is 128 bits, skipping eight ECC bits after 64.
// - Processor window exposes one 64MB segment at a time.
// - First control word selects the segment: 0x0 first, 0x1 second.
// - Second control word reads 0x1 when the controller is operational.
// - Same-row columns run back to back; row, bank, direction changes cost.
// - With bank opening, up to three banks stay open at once.
// - Accepted commands execute strictly in acceptance order.
package dcp_pkg;
  localparam int ADDR_W = 32;
  localparam int HALF_W = 144;
  localparam int UNIT_W = 288;
  localparam int HALF_BE = 18;
  localparam int UNIT_BE = 36;
  localparam int LANE_W = 72;
  localparam int LANE_DATA = 64;
  localparam int COL_LSB = 3;
  localparam int COL_MSB = 12;
  localparam int RANK_BIT = 13;
  localparam int ROW_LSB = 14;
  localparam int ROW_MSB = 27;
  localparam int BANK_LSB = 28;
  localparam int BANK_MSB = 29;
  localparam int LOC_W = 27;
  localparam int LIN_W = 26;
  localparam int LOC_BANK_LSB = 25;
  localparam int LOC_ROW_LSB = 11;
  localparam int ROW_W = 14;
  localparam int CPU_W = 128;
  localparam int CPU_BE = 16;
  localparam int CPU_LSB = 4;
  localparam int SEG_OFS_W = 22;
  localparam int REG_W = 32;
  localparam logic REG_SEGMENT = 1'h0;
  localparam logic REG_READY = 1'h1;
  localparam logic [REG_W-1:0] SEGMENT_RESET = 32'h0000_0000;
  localparam logic [REG_W-1:0] READY_VALUE = 32'h0000_0001;
  localparam int CLK_MHZ = 250;
  localparam int MC_DEFAULT_MHZ = 266;
  localparam int OPEN_BANKS = 3;
  localparam int ROW_MISS_MC = 8;
  localparam int DIR_TURN_MC = 16;
  localparam int INIT_NS = 200;
  localparam int INIT_CYC = (INIT_NS * CLK_MHZ + 999) / 1000;
  localparam int WAIT_W = 8;

  typedef struct packed {
    logic rnw;
    logic [LOC_W-1:0] loc;
    logic [UNIT_W-1:0] data;
    logic [UNIT_BE-1:0] be;
  } dcp_cmd_s;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WAIT = 5'b00010,
    ST_BEAT0 = 5'b00100,
    ST_BEAT1 = 5'b01000,
    ST_CPU = 5'b10000
  } dcp_state_e;

  // Supported controller rates, anything else falls back to the default
  function automatic int dcp_mc_clock(input int req);
    if (req == 150 || req == 200 || req == 266 || req == 300 || req == 333) begin
      return req;
    end
    return MC_DEFAULT_MHZ;
  endfunction

  // Memory-clock cycles to fabric cycles, rounded up, at least one
  function automatic int dcp_fab_cycles(input int mc_cyc, input int mc_mhz);
    int n;
    n = (mc_cyc * CLK_MHZ + mc_mhz - 1) / mc_mhz;
    return (n < 1) ? 1 : n;
  endfunction
endpackage

/* src/dcp_mem_if.sv */
// Port between the command engine and the storage array.
// Assumes both ends share the fabric clock.
`timescale 1ns/1ns
interface dcp_mem_if #(parameter int AW = 10);
  logic en;
  logic we;
  logic [AW-1:0] addr;
  logic [17:0] be;
  logic [143:0] wdata;
  logic [143:0] rdata;
  modport engine (output en, output we, output addr, output be, output wdata, input rdata);
  modport store (input en, input we, input addr, input be, input wdata, output rdata);
endinterface

/* src/dcp_store.sv */
// Storage array of 144-bit locations with byte writes and registered read data.
// Assumes the engine keeps one access per clock.
`timescale 1ns/1ns
module dcp_store #(parameter int AW = 10) (
  input wire logic clk,
  dcp_mem_if.store mp
);
  logic [143:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (mp.en && mp.we) begin
      for (int b = 0; b < 18; b++) begin
        if (mp.be[b]) begin
          mem[mp.addr][b*8 +: 8] <= mp.wdata[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (mp.en && !mp.we) begin
      mp.rdata <= mem[mp.addr];
    end
  end
endmodule

/* src/dcp_cmd_queue.sv */
// In-order command queue with valid/ready on both sides.
// Assumes a synchronous active-low reset.
`timescale 1ns/1ns
module dcp_cmd_queue #(parameter int W = 8, parameter int DEPTH = 8) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] slot [0:DEPTH-1];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = slot[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      slot[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end
endmodule

/* bench/dcp_checker.sv */
// Assertions on the command port, processor window and control words.
// Assumes binding onto dcp_top with its default parameters.
`timescale 1ns/1ns
module dcp_checker import dcp_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic read_not_write_select,
  input wire logic cmd_valid,
  input wire logic cmd_ack,
  input wire logic rd_valid,
  input wire logic cpu_done,
  input wire logic reg_wr,
  input wire logic reg_index,
  input wire logic [REG_W-1:0] reg_wdata,
  input wire logic [REG_W-1:0] reg_rdata
);
  int cyc;
  int words;
  always_ff @(posedge clk) begin
    if (!nrst) cyc <= 0;
    else if (cyc < 255) cyc <= cyc + 1;
  end
  // Words still owed by accepted reads
  always_ff @(posedge clk) begin
    if (!nrst) words <= 0;
    else words <= words + ((cmd_valid && read_not_write_select && cmd_ack) ? 2 : 0)
      - (rd_valid ? 1 : 0);
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ack_refuse_a: assert property (!cmd_ack |-> cmd_valid)
    else $error("cmd_ack low without a command");
  rd_pair_a: assert property ($rose(rd_valid) |=> rd_valid)
    else $error("read word pair broken");
  word_bal_a: assert property (words >= 0)
    else $error("read word without a read");
  ready_late_a: assert property (cyc + 2 < INIT_CYC && reg_index |=> reg_rdata == 32'h0)
    else $error("ready flag too early");
  ready_val_a: assert property (reg_index == REG_READY |=>
    reg_rdata == 32'h0 || reg_rdata == READY_VALUE) else $error("ready word value");
  seg_back_a: assert property (reg_wr && reg_index == REG_SEGMENT ##1 !reg_index
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("segment readback");
  cpu_pulse_a: assert property (cpu_done |=> !cpu_done)
    else $error("cpu_done longer than one cycle");
  cpu_wait_a: assert property (cpu_done |-> cyc >= INIT_CYC)
    else $error("cpu access before ready");
  rst_quiet_a: assert property (disable iff (1'b0) !nrst |=>
    !rd_valid && !cpu_done && reg_rdata == 32'h0) else $error("outputs busy in reset");
  cover property (!cmd_ack);
  cover property ($rose(rd_valid));
  cover property (cpu_done);
  cover property (reg_rdata == READY_VALUE);
endmodule
bind dcp_top dcp_checker chk (.clk, .nrst, .read_not_write_select, .cmd_valid, .cmd_ack,
  .rd_valid, .cpu_done, .reg_wr, .reg_index, .reg_wdata, .reg_rdata);

/* bench/dcp_user_model.sv */
// User fabric logic issuing commands on the command port.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ns
module dcp_user_model import dcp_pkg::*; (
  input wire logic clk,
  input wire logic cmd_ack,
  output logic [ADDR_W-1:0] address,
  output logic [UNIT_W-1:0] data_in,
  output logic [UNIT_BE-1:0] write_byte_lanes,
  output logic read_not_write_select,
  output logic cmd_valid
);
  initial begin
    address = 32'h0;
    data_in = '0;
    write_byte_lanes = 36'h0;
    read_not_write_select = 1'b0;
    cmd_valid = 1'b0;
  end
  // Halves go on the low lanes, the unused upper lanes carry junk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [UNIT_W-1:0] d,
    input logic [UNIT_BE-1:0] be, output logic ack);
    @(posedge clk);
    #1 address = a;
    read_not_write_select = 1'b0;
    cmd_valid = 1'b1;
    data_in = d;
    write_byte_lanes = be;
    @(posedge clk);
    #1 data_in = {d[HALF_W-1:0], d[UNIT_W-1:HALF_W]};
    write_byte_lanes = {be[HALF_BE-1:0], be[UNIT_BE-1:HALF_BE]};
    #2 ack = cmd_ack;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    data_in = ~data_in;
    address = ~a;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic ack);
    @(posedge clk);
    #1 address = a;
    read_not_write_select = 1'b1;
    cmd_valid = 1'b1;
    #2 ack = cmd_ack;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
  endtask
endmodule

/* bench/dcp_top_tb_top.sv */
// Self-checking bench of the command port, window and control words.
// Assumes dcp_top with default parameters and a queue of eight.
`timescale 1ns/1ns
module dcp_top_tb_top import dcp_pkg::*; ;
  localparam int QD = 8;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] address;
  logic [UNIT_W-1:0] data_in;
  logic [UNIT_BE-1:0] write_byte_lanes;
  logic read_not_write_select;
  logic cmd_valid;
  logic cmd_ack;
  logic [HALF_W-1:0] data_out;
  logic rd_valid;
  logic cpu_req = 1'b0;
  logic cpu_we = 1'b0;
  logic [LIN_W-1:0] cpu_addr = 26'h0;
  logic [CPU_W-1:0] cpu_wdata = 128'h0;
  logic [CPU_BE-1:0] cpu_be = 16'h0;
  logic [CPU_W-1:0] cpu_rdata;
  logic cpu_done;
  logic reg_wr = 1'b0;
  logic reg_index = 1'b0;
  logic [REG_W-1:0] reg_wdata = 32'h0;
  logic [REG_W-1:0] reg_rdata;
  int miscompares = 0;
  int n_checks = 0;
  logic [HALF_W-1:0] rq[$];
  always #2 clk = ~clk;
  always @(posedge clk) if (rd_valid === 1'b1) rq.push_back(data_out);
  dcp_top #(.QUEUE_DEPTH(QD)) DUT (.clk, .nrst, .address, .data_in, .write_byte_lanes,
    .read_not_write_select, .cmd_valid, .cmd_ack, .data_out, .rd_valid, .cpu_req, .cpu_we,
    .cpu_addr, .cpu_wdata, .cpu_be, .cpu_rdata, .cpu_done, .reg_wr, .reg_index, .reg_wdata,
    .reg_rdata);
  dcp_user_model user (.clk, .cmd_ack, .address, .data_in, .write_byte_lanes,
    .read_not_write_select, .cmd_valid);
  // ----
  // Shared tasks
  // ----
  task automatic chk(input string what, input logic [UNIT_W-1:0] exp,
    input logic [UNIT_W-1:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic reg_rd(input logic idx, output logic [REG_W-1:0] v);
    @(posedge clk);
    #1 reg_index = idx;
    @(posedge clk);
    #1 v = reg_rdata;
  endtask
  task automatic reg_wt(input logic [REG_W-1:0] v);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    reg_index = REG_SEGMENT;
    reg_wdata = v;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask
  task automatic get_words(input int n);
    for (int i = 0; i < 400 && rq.size() < n; i++) @(posedge clk);
    chk("word count", n, rq.size());
  endtask
  task automatic cpu_op(input logic we, input logic [CPU_W-1:0] c);
    @(posedge clk);
    #1 cpu_req = 1'b1;
    cpu_we = we;
    cpu_addr = 26'h20;
    cpu_wdata = c;
    cpu_be = 16'hFFFF;
    @(posedge clk);
    #1 cpu_req = 1'b0;
    cpu_wdata = ~c;
    for (int i = 0; i < 200 && cpu_done !== 1'b1; i++) @(posedge clk) #1;
    chk("cpu_done", 1'b1, cpu_done);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_full;
    logic a;
    logic [REG_W-1:0] v;
    int acc;
    acc = 0;
    reg_rd(REG_READY, v);
    chk("ready early", 32'h0, v);
    for (int i = 0; i < QD + 2; i++) begin
      user.rd(i * 8, a);
      if (a === 1'b1) acc++;
    end
    chk("accepted", QD, acc);
    for (int i = 0; i < 100 && v !== READY_VALUE; i++) reg_rd(REG_READY, v);
    chk("ready", READY_VALUE, v);
    get_words(2 * acc);
    repeat (60) @(posedge clk);
    chk("extra words", 2 * acc, rq.size());
    rq.delete();
  endtask
  task automatic t_seg;
    logic [REG_W-1:0] v;
    reg_wt(32'h0000_0001);
    reg_rd(REG_SEGMENT, v);
    chk("segment", 32'h0000_0001, v);
    reg_wt(32'h0000_0000);
    reg_rd(REG_SEGMENT, v);
    chk("segment", 32'h0000_0000, v);
  endtask
  task automatic t_order;
    logic a;
    logic [UNIT_W-1:0] d;
    logic [UNIT_W-1:0] e;
    d = {9{32'hA5C3_0F1E}};
    user.wr(32'h0000_0080, d, 36'hF_FFFF_FFFF, a);
    chk("write ack", 1'b1, a);
    user.rd(32'h0000_0087, a);
    get_words(2);
    chk("word0", d[HALF_W-1:0], rq.pop_front());
    chk("word1", d[UNIT_W-1:HALF_W], rq.pop_front());
    e = d;
    e[7:0] = ~d[7:0];
    e[151:144] = ~d[151:144];
    user.wr(32'h0000_0080, ~d, 36'h0_0004_0001, a);
    user.rd(32'hC800_0080, a);
    get_words(2);
    chk("lanes0", e[HALF_W-1:0], rq.pop_front());
    chk("lanes1", e[UNIT_W-1:HALF_W], rq.pop_front());
  endtask
  task automatic t_cpu;
    logic a;
    logic [CPU_W-1:0] c;
    logic [HALF_W-1:0] w;
    c = {4{32'h1357_9BDF}};
    cpu_op(1'b1, c);
    cpu_op(1'b0, ~c);
    chk("cpu read", c, cpu_rdata);
    user.rd(32'h0000_0010, a);
    get_words(2);
    w = rq.pop_front();
    chk("lane0", c[63:0], w[63:0]);
    chk("lane1", c[127:64], w[135:72]);
    rq.delete();
  endtask
  // Sixteen units written as one long same-direction burst, then read back as a second one
  task automatic t_burst;
    logic a;
    logic [ADDR_W-1:0] b;
    logic [UNIT_W-1:0] d;
    for (int i = 0; i < 16; i++) begin
      b = 32'h0000_0400 + 32'(i * 16);
      d = {9{32'h5A5A_0000 + 32'(i)}};
      a = 1'b0;
      for (int k = 0; k < 20 && a !== 1'b1; k++) begin
        user.wr(b, d, 36'hF_FFFF_FFFF, a);
      end
    end
    for (int i = 0; i < 16; i++) begin
      b = 32'h0000_0400 + 32'(i * 16);
      a = 1'b0;
      for (int k = 0; k < 20 && a !== 1'b1; k++) begin
        user.rd(b, a);
      end
    end
    get_words(32);
    for (int i = 0; i < 32; i++) begin
      d = {9{32'h5A5A_0000 + 32'(i / 2)}};
      chk("burst word", (i % 2) ? d[UNIT_W-1:HALF_W] : d[HALF_W-1:0],
        rq.pop_front());
    end
    rq.delete();
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    t_full;
    t_seg;
    t_order;
    t_cpu;
    t_burst;
    final_report;
  end
  initial begin
    #(20000 * 4);
    miscompares++;
    final_report;
  end
endmodule
